// ### apbwd_pkg.sv
// Package of register map, field layout and types for the APB watchdog timer
`default_nettype none
package apbwd_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE      = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE       = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_CONTROL           = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CLEAR   = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_RAW_IRQ_STATUS    = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_MASKED_IRQ_STATUS = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_WRITE_LOCK        = 12'hC00;

	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_INT_EN_BIT = 0;
	localparam int unsigned CTRL_RST_EN_BIT = 1;
	localparam int unsigned FLAG_BIT        = 0;

	localparam logic [DATA_W-1:0] RELOAD_RESET   = 32'hFFFFFFFF;
	localparam logic [DATA_W-1:0] COUNT_RESET    = 32'hFFFFFFFF;
	localparam logic [DATA_W-1:0] LOCK_KEY       = 32'h1ACCE551;
	localparam logic [DATA_W-1:0] LOCK_RD_OPEN   = 32'h00000000;
	localparam logic [DATA_W-1:0] LOCK_RD_LOCKED = 32'h00000001;
	localparam logic [DATA_W-1:0] ZERO_WORD      = 32'h00000000;
	localparam logic [DATA_W-1:0] ONE_WORD       = 32'h00000001;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apbwd_req_s;

	// Gray order along idle -> load -> count -> stop
	typedef enum logic [1:0] {
		WD_IDLE  = 2'h0,
		WD_LOAD  = 2'h1,
		WD_COUNT = 2'h3,
		WD_STOP  = 2'h2
	} apbwd_state_e;

endpackage : apbwd_pkg
`default_nettype wire

// ### apbwd_timer.sv
// APB watchdog timer: register slave, down-counter, interrupt and timeout reset
//
// Notes on behaviour
// - Writing the reload value restarts the count from it at once.
// - A reload value of zero raises the interrupt immediately.
// - Count value is read-only and shows the live counter.
// - Control bit 1 masks the timeout reset output.
// - Control bit 0 enables counter and interrupt; clearing it halts both.
// - Enable rising reloads the counter before counting resumes.
// - Any write to interrupt clear clears the flag and reloads.
// - Raw status bit 0 shows the flag regardless of enable; others zero.
// - Masked status equals raw AND enable and drives the interrupt pin.
// - Writing the key unlocks all register writes.
// - Writing anything else locks; other register writes are ignored.
// - Lock read returns 1 when locked, 0 when unlocked.
// - Control bits 31 to 2 are reserved and read zero.
// - Write signal high means write, low means read.
// - Interrupt output is active high.
// - Timeout reset output is active high.
// - Counter reset input is active low.
// - Bus reset is active low and resets register state.
// - Counter decrements only on clock edges with enable high.
// - At zero: raise interrupt, reload, start again.
// - Zero again with flag pending and reset enabled: assert reset, stop.
// - Interrupt clear drops the interrupt output without waiting for enable.
`timescale 1ns/1ps
`default_nettype none
module apbwd_timer
	import apbwd_pkg::*;
#(
	parameter int unsigned CNT_W = DATA_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire apbwd_req_s        apb_req,
	output logic [DATA_W-1:0]      prdata,
	input  wire logic              counter_clock_enable,
	input  wire logic              counter_reset_n,
	output logic                   timeout_irq,
	output logic                   timeout_reset_out
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	generate
		if (CNT_W != DATA_W) begin : g_bad_width
			$error("apbwd_timer: CNT_W must equal the bus data width");
		end
	endgenerate

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction : reg_hit

	// ------------------------------------------------------------
	// Counter reset synchroniser
	// ------------------------------------------------------------
	logic cnt_rst_meta;
	logic cnt_rst_n;

	// Asserted from outside the clock, so two stages before use
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_rst_meta <= 1'b0;
			cnt_rst_n    <= 1'b0;
		end else begin
			cnt_rst_meta <= counter_reset_n;
			cnt_rst_n    <= cnt_rst_meta;
		end
	end

	logic cnt_clear;
	assign cnt_clear = !rstn || !cnt_rst_n;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic                locked;
	logic [CNT_W-1:0]    reload_value;
	logic                ctrl_int_en;
	logic                ctrl_rst_en;
	logic [CNT_W-1:0]    count_value;
	logic                raw_irq_flag;
	logic                rst_flag;
	apbwd_state_e        state;

	logic wr_access;
	logic rd_setup;
	logic wr_ok;
	logic wr_reload;
	logic wr_control;
	logic wr_clear;
	logic wr_lock;

	assign wr_access  = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_setup   = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign wr_lock    = wr_access && reg_hit(apb_req.paddr, OFS_WRITE_LOCK);
	assign wr_ok      = wr_access && !locked;
	assign wr_reload  = wr_ok && reg_hit(apb_req.paddr, OFS_RELOAD_VALUE);
	assign wr_control = wr_ok && reg_hit(apb_req.paddr, OFS_CONTROL);
	assign wr_clear   = wr_ok && reg_hit(apb_req.paddr, OFS_INTERRUPT_CLEAR);

	// ------------------------------------------------------------
	// Bus-side registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			locked <= 1'b0;
		end else if (wr_lock) begin
			locked <= (apb_req.pwdata != LOCK_KEY);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reload_value <= RELOAD_RESET;
		end else if (wr_reload) begin
			reload_value <= apb_req.pwdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl_int_en <= 1'b0;
			ctrl_rst_en <= 1'b0;
		end else if (wr_control) begin
			ctrl_int_en <= apb_req.pwdata[CTRL_INT_EN_BIT];
			ctrl_rst_en <= apb_req.pwdata[CTRL_RST_EN_BIT];
		end
	end

	// ------------------------------------------------------------
	// Down-counter
	// ------------------------------------------------------------
	logic tick;
	logic zero_hit;

	assign tick     = counter_clock_enable;
	// Zero reload fires on the loading edge itself
	assign zero_hit = tick && ctrl_int_en && ((state == WD_COUNT && count_value == ZERO_WORD)
		|| (state == WD_LOAD && reload_value == ZERO_WORD));

	always_ff @(posedge clk_sys) begin
		if (cnt_clear) begin
			state <= WD_IDLE;
		end else if (!ctrl_int_en) begin
			if (state != WD_STOP) begin
				state <= WD_IDLE;
			end
		end else begin
			unique case (state)
				WD_IDLE: begin
					state <= wr_reload ? WD_COUNT : WD_LOAD;
				end
				WD_LOAD: begin
					if (wr_reload || wr_clear || tick) begin
						state <= WD_COUNT;
					end
				end
				WD_COUNT: begin
					if (zero_hit && raw_irq_flag && ctrl_rst_en) begin
						state <= WD_STOP;
					end
				end
				WD_STOP: begin
					state <= WD_STOP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (cnt_clear) begin
			count_value <= COUNT_RESET;
		end else if (state == WD_STOP) begin
			count_value <= count_value;
		end else if (wr_reload) begin
			count_value <= apb_req.pwdata;
		end else if (wr_clear) begin
			count_value <= reload_value;
		end else if (ctrl_int_en && tick && state != WD_IDLE) begin
			if (state == WD_LOAD || count_value == ZERO_WORD) begin
				count_value <= reload_value;
			end else begin
				count_value <= count_value - ONE_WORD;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt and reset flags
	// ------------------------------------------------------------
	// A zero hit in the clearing cycle keeps the flag set
	always_ff @(posedge clk_sys) begin
		if (cnt_clear) begin
			raw_irq_flag <= 1'b0;
		end else if (zero_hit && state != WD_STOP) begin
			raw_irq_flag <= 1'b1;
		end else if (wr_clear) begin
			raw_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (cnt_clear) begin
			rst_flag <= 1'b0;
		end else if (state == WD_COUNT && zero_hit && raw_irq_flag && ctrl_rst_en) begin
			rst_flag <= 1'b1;
		end
	end

	// Combinational so a clear write drops the pin without a tick
	assign timeout_irq       = raw_irq_flag && ctrl_int_en;
	assign timeout_reset_out = rst_flag && ctrl_rst_en;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [DATA_W-1:0] next_prdata;

	always_comb begin
		next_prdata = ZERO_WORD;
		if (reg_hit(apb_req.paddr, OFS_RELOAD_VALUE)) begin
			next_prdata = reload_value;
		end else if (reg_hit(apb_req.paddr, OFS_COUNT_VALUE)) begin
			next_prdata = count_value;
		end else if (reg_hit(apb_req.paddr, OFS_CONTROL)) begin
			next_prdata[CTRL_INT_EN_BIT] = ctrl_int_en;
			next_prdata[CTRL_RST_EN_BIT] = ctrl_rst_en;
		end else if (reg_hit(apb_req.paddr, OFS_RAW_IRQ_STATUS)) begin
			next_prdata[FLAG_BIT] = raw_irq_flag;
		end else if (reg_hit(apb_req.paddr, OFS_MASKED_IRQ_STATUS)) begin
			next_prdata[FLAG_BIT] = timeout_irq;
		end else if (reg_hit(apb_req.paddr, OFS_WRITE_LOCK)) begin
			next_prdata = locked ? LOCK_RD_LOCKED : LOCK_RD_OPEN;
		end
	end

	// Captured in setup so the access phase sees stable data
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata <= ZERO_WORD;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (cnt_clear);

	// Idle needs one edge to reach load after the enable bit rises
	sequence s_enable_rise;
		!ctrl_int_en ##1 ctrl_int_en ##1 ctrl_int_en && state == WD_LOAD;
	endsequence

	sequence s_load_edge;
		tick && !wr_reload && !wr_clear;
	endsequence

	property p_reload_restart;
		wr_reload && state != WD_STOP |=> count_value == $past(apb_req.pwdata);
	endproperty
	a_reload_restart: assert property (p_reload_restart) else $error("reload write did not restart count");

	property p_zero_reload;
		state == WD_LOAD && ctrl_int_en && tick && reload_value == ZERO_WORD && !wr_reload |=> raw_irq_flag;
	endproperty
	a_zero_reload: assert property (p_zero_reload) else $error("zero reload did not raise interrupt");

	property p_count_read;
		rd_setup && reg_hit(apb_req.paddr, OFS_COUNT_VALUE) |=> prdata == $past(count_value);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read mismatch");

	property p_reset_mask;
		!ctrl_rst_en |-> !timeout_reset_out;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("reset output not masked");

	property p_halt;
		!ctrl_int_en && !wr_reload && !wr_clear |=> $stable(count_value);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while disabled");

	property p_enable_reload;
		s_enable_rise ##0 s_load_edge |=> count_value == $past(reload_value);
	endproperty
	a_enable_reload: assert property (p_enable_reload) else $error("enable rise did not reload");

	property p_clear;
		wr_clear && !zero_hit |=> !raw_irq_flag && !timeout_irq;
	endproperty
	a_clear: assert property (p_clear) else $error("interrupt clear failed");

	property p_masked;
		rd_setup && reg_hit(apb_req.paddr, OFS_MASKED_IRQ_STATUS)
			|=> prdata == {{(DATA_W-1){1'b0}}, $past(raw_irq_flag && ctrl_int_en)};
	endproperty
	a_masked: assert property (p_masked) else $error("masked status mismatch");

	property p_unlock;
		wr_lock && apb_req.pwdata == LOCK_KEY |=> !locked;
	endproperty
	a_unlock: assert property (p_unlock) else $error("key did not unlock");

	property p_locked_ignore;
		locked && wr_access && reg_hit(apb_req.paddr, OFS_RELOAD_VALUE) |=> $stable(reload_value);
	endproperty
	a_locked_ignore: assert property (p_locked_ignore) else $error("write accepted while locked");

	property p_lock_read;
		rd_setup && reg_hit(apb_req.paddr, OFS_WRITE_LOCK) |=> prdata == ($past(locked) ? LOCK_RD_LOCKED : LOCK_RD_OPEN);
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock read mismatch");

	property p_decrement;
		state == WD_COUNT && ctrl_int_en && tick && count_value != ZERO_WORD && !wr_reload && !wr_clear
			|=> count_value == $past(count_value) - ONE_WORD;
	endproperty
	a_decrement: assert property (p_decrement) else $error("decrement wrong");

	property p_no_tick;
		!tick && !wr_reload && !wr_clear |=> $stable(count_value);
	endproperty
	a_no_tick: assert property (p_no_tick) else $error("count moved without enable");

	property p_zero_wrap;
		state == WD_COUNT && zero_hit && !raw_irq_flag && !wr_reload && !wr_clear
			|=> raw_irq_flag && count_value == $past(reload_value);
	endproperty
	a_zero_wrap: assert property (p_zero_wrap) else $error("zero did not raise and reload");

	property p_timeout;
		state == WD_COUNT && zero_hit && raw_irq_flag && ctrl_rst_en |=> timeout_reset_out && state == WD_STOP ##1 $stable(count_value);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout reset or stop missing");

	property p_raw_hold;
		raw_irq_flag && !wr_clear |=> raw_irq_flag;
	endproperty
	a_raw_hold: assert property (p_raw_hold) else $error("raw flag dropped without clear");

endmodule : apbwd_timer
`default_nettype wire

// ### apbwd_apb_master.sv
// Bus master model that drives the watchdog register slave
`timescale 1ns/1ps
`default_nettype none
module apbwd_apb_master
	import apbwd_pkg::*;
(
	input  wire logic              clk_sys,
	output var apbwd_req_s         apb_req,
	input  wire logic [DATA_W-1:0] prdata,
	output logic                   rd_done,
	output logic [DATA_W-1:0]      rd_data
);
	initial begin
		apb_req = '0;
		rd_done = 1'b0;
		rd_data = '0;
	end

	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk_sys);
		apb_req.psel   = 1'b1;
		apb_req.pwrite = wr;
		apb_req.paddr  = a;
		apb_req.pwdata = d;
		@(negedge clk_sys);
		apb_req.penable = 1'b1;
		@(posedge clk_sys);
		if (!wr) begin
			rd_data = prdata;
			rd_done = 1'b1;
		end
		@(negedge clk_sys);
		// Released bus shows inverted leftovers, never the stale values
		apb_req = '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
		rd_done = 1'b0;
	endtask : xfer
endmodule : apbwd_apb_master
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the APB watchdog timer
`timescale 1ns/1ps
`default_nettype none
module testbench
	import apbwd_pkg::*;
;
	logic              clk_sys;
	logic              rstn;
	logic              counter_clock_enable;
	logic              counter_reset_n;
	apbwd_req_s        apb_req;
	logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd_data;
	logic              rd_done;
	logic              timeout_irq;
	logic              timeout_reset_out;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] r;
	logic [DATA_W-1:0] v;
	int                bad_count;
	int                tests_run;
	int                seed;
	int                n;
	int                e;

	apbwd_timer u_apbwd_timer (.clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req), .prdata(prdata),
		.counter_clock_enable(counter_clock_enable), .counter_reset_n(counter_reset_n),
		.timeout_irq(timeout_irq), .timeout_reset_out(timeout_reset_out));
	apbwd_apb_master u_apbwd_apb_master (.clk_sys(clk_sys), .apb_req(apb_req), .prdata(prdata),
		.rd_done(rd_done), .rd_data(rd_data));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		u_apbwd_apb_master.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		exp_q.push_back(x);
		u_apbwd_apb_master.xfer(1'b0, a, '0);
	endtask : rd

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] x);
		tests_run++;
		if (got !== x) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, got, x);
		end
	endtask : chk

	// Bounded wait for a pin, sampled at falling edges where it is settled
	task automatic wait_pin(input bit sel, input int hi, output int cnt);
		cnt = 0;
		while ((sel ? timeout_reset_out : timeout_irq) !== 1'b1 && cnt < hi) begin
			@(negedge clk_sys);
			cnt++;
		end
	endtask : wait_pin

	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	always @(posedge rd_done) begin
		if (exp_q.size() > 0)
			chk(rd_data, exp_q.pop_front());
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'hA5D1;
		bad_count = 0;
		tests_run = 0;
		rstn = 1'b0;
		counter_reset_n = 1'b0;
		counter_clock_enable = 1'b0;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		counter_reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(OFS_RELOAD_VALUE, RELOAD_RESET);
		rd(OFS_COUNT_VALUE, COUNT_RESET);
		rd(OFS_CONTROL, ZERO_WORD);
		rd(OFS_RAW_IRQ_STATUS, ZERO_WORD);
		rd(OFS_MASKED_IRQ_STATUS, ZERO_WORD);
		rd(OFS_WRITE_LOCK, LOCK_RD_OPEN);
		rd(OFS_INTERRUPT_CLEAR, ZERO_WORD);
		rd(12'h018, ZERO_WORD);
		r = 32'h4 + ($random(seed) & 32'h7);
		wr(OFS_CONTROL, ONE_WORD);
		wr(OFS_RELOAD_VALUE, r);
		rd(OFS_COUNT_VALUE, r);
		repeat (20) @(negedge clk_sys);
		rd(OFS_COUNT_VALUE, r);
		wr(OFS_CONTROL, ZERO_WORD);
		counter_clock_enable = 1'b1;
		repeat (20) @(negedge clk_sys);
		rd(OFS_COUNT_VALUE, r);
		wr(OFS_CONTROL, ONE_WORD);
		wait_pin(1'b0, r + 8, n);
		chk(32'(n), r + 32'h3);
		rd(OFS_RAW_IRQ_STATUS, ONE_WORD);
		rd(OFS_MASKED_IRQ_STATUS, ONE_WORD);
		wr(OFS_RELOAD_VALUE, r);
		rd(OFS_RAW_IRQ_STATUS, ONE_WORD);
		wr(OFS_CONTROL, ZERO_WORD);
		chk(32'(timeout_irq), ZERO_WORD);
		rd(OFS_RAW_IRQ_STATUS, ONE_WORD);
		rd(OFS_MASKED_IRQ_STATUS, ZERO_WORD);
		wr(OFS_CONTROL, ONE_WORD);
		e = 0;
		repeat (40) begin
			@(negedge clk_sys);
			if (timeout_reset_out !== 1'b0)
				e++;
		end
		chk(32'(e), ZERO_WORD);
		wr(OFS_CONTROL, 32'h3);
		wait_pin(1'b1, 2 * r + 10, n);
		chk(32'(timeout_reset_out), ONE_WORD);
		wr(OFS_INTERRUPT_CLEAR, $random(seed));
		chk(32'(timeout_irq), ZERO_WORD);
		rd(OFS_RAW_IRQ_STATUS, ZERO_WORD);
		counter_reset_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		counter_reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(32'(timeout_reset_out), ZERO_WORD);
		wr(OFS_CONTROL, 32'hFFFFFFFF);
		rd(OFS_CONTROL, 32'h00000003);
		wr(OFS_CONTROL, ZERO_WORD);
		v = $random(seed);
		if (v === LOCK_KEY)
			v = ~v;
		wr(OFS_WRITE_LOCK, v);
		rd(OFS_WRITE_LOCK, LOCK_RD_LOCKED);
		wr(OFS_RELOAD_VALUE, ~r);
		rd(OFS_RELOAD_VALUE, r);
		wr(OFS_WRITE_LOCK, LOCK_KEY);
		rd(OFS_WRITE_LOCK, LOCK_RD_OPEN);
		wr(OFS_INTERRUPT_CLEAR, ZERO_WORD);
		wr(OFS_RELOAD_VALUE, ZERO_WORD);
		rd(OFS_RELOAD_VALUE, ZERO_WORD);
		wr(OFS_CONTROL, ONE_WORD);
		wait_pin(1'b0, 6, n);
		chk(32'(timeout_irq), ONE_WORD);
		chk(32'(n), 32'h2);
		rstn = 1'b0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(OFS_RELOAD_VALUE, RELOAD_RESET);
		rd(OFS_CONTROL, ZERO_WORD);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
